// [design/wpt_pkg.sv]
package wpt_pkg;

    localparam int unsigned SAMPLE_W = 12;
    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned CNT_W    = 8;

    localparam logic [ADDR_W-1:0] GLOBAL_TRIGGER_SOURCE_OFS      = 16'h9C40;
    localparam logic [ADDR_W-1:0] CHANNEL0_TRIGGER_CONDITION_OFS = 16'h9D08;
    localparam logic [ADDR_W-1:0] WINDOW_UPPER_LEVEL_OFS         = 16'hA410;
    localparam logic [ADDR_W-1:0] WINDOW_LOWER_LEVEL_OFS         = 16'hA474;
    localparam logic [ADDR_W-1:0] QUALIFY_DURATION_SAMPLES_OFS   = 16'hABE0;

    localparam logic [DATA_W-1:0] CHANNEL_TRIGGER_SELECT = 32'h00004E48;
    localparam logic [DATA_W-1:0] LONG_INNER_MODE        = 32'h00002739;
    localparam logic [DATA_W-1:0] SHORT_INNER_MODE       = 32'h0000273A;
    localparam logic [DATA_W-1:0] LONG_OUTER_MODE        = 32'h00002743;
    localparam logic [DATA_W-1:0] SHORT_OUTER_MODE       = 32'h00002744;

    localparam logic [DATA_W-1:0] GLOBAL_SOURCE_RST   = 32'h00000000;
    localparam logic [DATA_W-1:0] CONDITION_RST       = 32'h00000000;
    localparam logic [DATA_W-1:0] UPPER_LEVEL_RST     = 32'h00000000;
    localparam logic [DATA_W-1:0] LOWER_LEVEL_RST     = 32'h00000000;
    localparam logic [DATA_W-1:0] DURATION_RST        = 32'h00000002;

    typedef enum logic [2:0] {
        WPT_IDLE    = 3'b001,
        WPT_QUALIFY = 3'b010,
        WPT_DONE    = 3'b100
    } wpt_state_t;

endpackage

// [design/wpt_cfg_if.sv]
`timescale 1ns/1ps
interface wpt_cfg_if;
    import wpt_pkg::*;
    logic                      enable;
    logic                      inner_mode;
    logic                      long_mode;
    logic signed [SAMPLE_W-1:0] upper;
    logic signed [SAMPLE_W-1:0] lower;
    logic [CNT_W-1:0]          duration;
    logic                      restart;

    modport source (output enable, inner_mode, long_mode, upper, lower,
                    duration, restart);
    modport sink   (input enable, inner_mode, long_mode, upper, lower,
                    duration, restart);
endinterface

// [design/wpt_qualifier.sv]
`timescale 1ns/1ps
module wpt_qualifier
    import wpt_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    wpt_cfg_if.sink                          cfg,
    input  wire logic                        sample_valid,
    input  wire logic signed [SAMPLE_W-1:0]  sample,
    output logic                             trigger,
    output logic                             qualifying
);
    import wpt_pkg::*;

    function automatic logic in_window(input logic signed [SAMPLE_W-1:0] s,
                                       input logic signed [SAMPLE_W-1:0] lo,
                                       input logic signed [SAMPLE_W-1:0] hi);
        in_window = (s >= lo) && (s <= hi);
    endfunction

    wpt_state_t       state_reg,  state_next;
    logic [CNT_W-1:0] count_reg,  count_next;
    logic             inside_reg, inside_next;
    logic             primed_reg, primed_next;
    logic             trig_reg,   trig_next;
    logic             inside_now;
    logic             start_hit;
    logic             stop_hit;
    logic             expired;

    ////////////////////////////////////////////////////////////////////////
    // Classification and qualification.

    always_comb begin
        inside_now  = in_window(sample, cfg.lower, cfg.upper);
        // Entry starts inner modes, exit starts outer modes.
        if (cfg.inner_mode) begin
            start_hit = primed_reg && inside_now && !inside_reg;
            stop_hit  = !inside_now;
        end else begin
            start_hit = primed_reg && !inside_now && inside_reg;
            stop_hit  = inside_now;
        end
        // Expiry looks at the count that this sample would reach.
        expired     = ((count_reg + 8'h01) >= cfg.duration);
        state_next  = state_reg;
        count_next  = count_reg;
        inside_next = inside_reg;
        primed_next = primed_reg;
        trig_next   = 1'b0;
        if (cfg.restart || !cfg.enable) begin
            state_next  = WPT_IDLE;
            count_next  = '0;
            primed_next = 1'b0;
        end else if (sample_valid) begin
            inside_next = inside_now;
            primed_next = 1'b1;
            count_next  = count_reg + 8'h01;
            case (state_reg)
                WPT_IDLE, WPT_DONE: begin
                    count_next = '0;
                    state_next = WPT_IDLE;
                end
                WPT_QUALIFY: begin
                    if (stop_hit) begin
                        trig_next  = !cfg.long_mode;
                        state_next = WPT_DONE;
                    end else if (expired) begin
                        trig_next  = cfg.long_mode;
                        state_next = WPT_DONE;
                    end
                end
                default: begin
                    state_next = WPT_IDLE;
                end
            endcase
            if (start_hit) begin
                state_next = WPT_QUALIFY;
                count_next = 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg  <= WPT_IDLE;
            count_reg  <= '0;
            inside_reg <= 1'b0;
            primed_reg <= 1'b0;
            trig_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            count_reg  <= count_next;
            inside_reg <= inside_next;
            primed_reg <= primed_next;
            trig_reg   <= trig_next;
        end
    end

    assign trigger    = trig_reg;
    assign qualifying = (state_reg == WPT_QUALIFY);

endmodule

// [design/wpt_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Evaluate every sample outside a mapped-write cycle while global source holds channel-trigger code and condition holds one of the four modes.
// - Upper and lower levels bound a window in input-range units.
// - Inner modes start the counter when the signal enters the window.
// - Long-inner: leaving before expiry suppresses the trigger.
// - Long-inner: expiry while still inside raises a trigger.
// - Short-inner: expiry while still inside gives no trigger.
// - Short-inner: leaving before expiry raises a trigger.
// - Outer modes start the counter when the signal leaves the window.
// - Long-outer: re-entry before expiry suppresses the trigger.
// - Long-outer: expiry while still outside raises a trigger.
// - Short-outer: expiry while still outside gives no trigger.
// - Short-outer: re-entry before expiry raises a trigger.
// - Counter expires after the programmed number of samples, but never before 2.
module wpt_top
    import wpt_pkg::*;
(
    input  wire logic                             clk,
    input  wire logic                             rst_b,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    input  wire logic [wpt_pkg::ADDR_W-1:0]       reg_addr,
    input  wire logic [wpt_pkg::DATA_W-1:0]       reg_wdata,
    output logic      [wpt_pkg::DATA_W-1:0]       reg_rdata,
    input  wire logic                             sample_valid,
    input  wire logic signed [wpt_pkg::SAMPLE_W-1:0] sample,
    output logic                                  trigger,
    output logic                                  qualifying
);
    import wpt_pkg::*;

    logic [DATA_W-1:0] source_reg,    source_next;
    logic [DATA_W-1:0] condition_reg, condition_next;
    logic [DATA_W-1:0] upper_reg,     upper_next;
    logic [DATA_W-1:0] lower_reg,     lower_next;
    logic [DATA_W-1:0] duration_reg,  duration_next;
    logic [DATA_W-1:0] rdata_reg,     rdata_next;
    logic              restart_next;
    logic              mode_ok;

    wpt_cfg_if cfg ();

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    always_comb begin
        source_next    = source_reg;
        condition_next = condition_reg;
        upper_next     = upper_reg;
        lower_next     = lower_reg;
        duration_next  = duration_reg;
        restart_next   = 1'b0;
        rdata_next     = rdata_reg;
        if (reg_wr) begin
            restart_next = 1'b1;
            case (reg_addr)
                GLOBAL_TRIGGER_SOURCE_OFS:      source_next    = reg_wdata;
                CHANNEL0_TRIGGER_CONDITION_OFS: condition_next = reg_wdata;
                WINDOW_UPPER_LEVEL_OFS:         upper_next     = reg_wdata;
                WINDOW_LOWER_LEVEL_OFS:         lower_next     = reg_wdata;
                QUALIFY_DURATION_SAMPLES_OFS:   duration_next  = reg_wdata;
                default:                        restart_next   = 1'b0;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                GLOBAL_TRIGGER_SOURCE_OFS:      rdata_next = source_reg;
                CHANNEL0_TRIGGER_CONDITION_OFS: rdata_next = condition_reg;
                WINDOW_UPPER_LEVEL_OFS:         rdata_next = upper_reg;
                WINDOW_LOWER_LEVEL_OFS:         rdata_next = lower_reg;
                QUALIFY_DURATION_SAMPLES_OFS:   rdata_next = duration_reg;
                default:                        rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            source_reg    <= GLOBAL_SOURCE_RST;
            condition_reg <= CONDITION_RST;
            upper_reg     <= UPPER_LEVEL_RST;
            lower_reg     <= LOWER_LEVEL_RST;
            duration_reg  <= DURATION_RST;
            rdata_reg     <= '0;
        end else begin
            source_reg    <= source_next;
            condition_reg <= condition_next;
            upper_reg     <= upper_next;
            lower_reg     <= lower_next;
            duration_reg  <= duration_next;
            rdata_reg     <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode feeding the qualifier.

    always_comb begin
        mode_ok = (condition_reg == LONG_INNER_MODE)
               || (condition_reg == SHORT_INNER_MODE)
               || (condition_reg == LONG_OUTER_MODE)
               || (condition_reg == SHORT_OUTER_MODE);
    end

    assign cfg.enable     = (source_reg == CHANNEL_TRIGGER_SELECT)
                         && mode_ok;
    assign cfg.inner_mode = (condition_reg == LONG_INNER_MODE)
                         || (condition_reg == SHORT_INNER_MODE);
    assign cfg.long_mode  = (condition_reg == LONG_INNER_MODE)
                         || (condition_reg == LONG_OUTER_MODE);
    assign cfg.upper      = upper_reg[SAMPLE_W-1:0];
    assign cfg.lower      = lower_reg[SAMPLE_W-1:0];
    assign cfg.duration   = duration_reg[CNT_W-1:0];
    // A mapped write aborts the pending qualification at its own edge.
    assign cfg.restart    = restart_next;

    wpt_qualifier u_qual (
        .clk          (clk),
        .rst_b        (rst_b),
        .cfg          (cfg),
        .sample_valid (sample_valid),
        .sample       (sample),
        .trigger      (trigger),
        .qualifying   (qualifying)
    );

    assign reg_rdata = rdata_reg;

endmodule

// [sim/wpt_adc_model.sv]
`timescale 1ns/1ps
module wpt_adc_model (
    input  wire logic                           clk,
    output logic                                sample_valid,
    output logic signed [wpt_pkg::SAMPLE_W-1:0] sample
);
    import wpt_pkg::*;
    initial begin
        sample_valid = 1'b0;
        sample       = '0;
    end
    ////////////////////////////////////////////////////////////
    // Idle cycles invert the data lines, so the last sample shows again on every second idle cycle.
    task automatic send(input logic signed [SAMPLE_W-1:0] s, input int gap);
        repeat (gap) begin
            @(negedge clk);
            sample_valid <= 1'b0;
            sample       <= ~sample;
        end
        @(negedge clk);
        sample_valid <= 1'b1;
        sample       <= s;
    endtask
    task automatic stop();
        @(negedge clk);
        sample_valid <= 1'b0;
        sample       <= ~sample;
    endtask
endmodule

// [sim/wpt_assertions.sv]
`timescale 1ns/1ps
module wpt_assertions (
    input wire logic                          clk,
    input wire logic                          rst_b,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [wpt_pkg::ADDR_W-1:0]    reg_addr,
    input wire logic [wpt_pkg::DATA_W-1:0]    reg_wdata,
    input wire logic [wpt_pkg::DATA_W-1:0]    reg_rdata,
    input wire logic                          sample_valid,
    input wire logic signed [wpt_pkg::SAMPLE_W-1:0] sample,
    input wire logic                          trigger,
    input wire logic                          qualifying
);
    import wpt_pkg::*;
    logic [DATA_W-1:0] src, cnd, up, lw, dur;
    logic [7:0]        n;
    logic              en, inr, lng, ins, map;
    int                dm;
    assign map = reg_addr inside {GLOBAL_TRIGGER_SOURCE_OFS,
        CHANNEL0_TRIGGER_CONDITION_OFS, WINDOW_UPPER_LEVEL_OFS,
        WINDOW_LOWER_LEVEL_OFS, QUALIFY_DURATION_SAMPLES_OFS};
    assign inr = cnd == LONG_INNER_MODE || cnd == SHORT_INNER_MODE;
    assign lng = cnd == LONG_INNER_MODE || cnd == LONG_OUTER_MODE;
    assign en  = src == CHANNEL_TRIGGER_SELECT &&
                 (inr || lng || cnd == SHORT_OUTER_MODE);
    assign ins = sample >= $signed(lw[11:0]) && sample <= $signed(up[11:0]);
    assign dm  = dur[7:0] < 8'h02 ? 2 : int'(dur[7:0]);
    // Shadow registers and a count of samples taken while qualifying.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            src <= GLOBAL_SOURCE_RST;
            cnd <= CONDITION_RST;
            up  <= UPPER_LEVEL_RST;
            lw  <= LOWER_LEVEL_RST;
            dur <= DURATION_RST;
            n   <= 8'h00;
        end else begin
            n <= qualifying ? n + 8'(sample_valid) : 8'h00;
            if (reg_wr) begin
                case (reg_addr)
                    GLOBAL_TRIGGER_SOURCE_OFS:      src <= reg_wdata;
                    CHANNEL0_TRIGGER_CONDITION_OFS: cnd <= reg_wdata;
                    WINDOW_UPPER_LEVEL_OFS:         up  <= reg_wdata;
                    WINDOW_LOWER_LEVEL_OFS:         lw  <= reg_wdata;
                    QUALIFY_DURATION_SAMPLES_OFS:   dur <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    trig_after_qual_a: assert property (
        trigger |-> $past(qualifying) && $past(sample_valid) && !qualifying)
        else $error("trigger without a running qualification");
    write_abort_a: assert property (
        reg_wr && map |=> !qualifying && !trigger)
        else $error("register write did not abort");
    idle_hold_a: assert property (
        !sample_valid && !reg_wr |=> $stable(qualifying) && !trigger)
        else $error("state moved without a sample");
    off_quiet_a: assert property (!en |-> !qualifying && !trigger)
        else $error("activity while disabled");
    start_cross_a: assert property (
        $rose(qualifying) |-> $past(ins) == inr)
        else $error("count started on the wrong side");
    qual_len_a: assert property (qualifying |-> int'(n) <= dm - 2)
        else $error("qualification outlived its duration");
    trig_level_a: assert property (
        trigger |-> $past(ins) == (inr == lng))
        else $error("trigger with the signal on the wrong side");
    long_time_a: assert property (
        trigger && lng |-> int'($past(n)) == dm - 2)
        else $error("long trigger at the wrong count");
endmodule
bind wpt_top wpt_assertions chk (.clk(clk), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample(sample), .trigger(trigger),
    .qualifying(qualifying));

// [sim/wpt_top_test.sv]
`timescale 1ns/1ps
module wpt_top_test;
    import wpt_pkg::*;
    logic                       clk, rst_b, reg_wr, reg_rd;
    logic [ADDR_W-1:0]          reg_addr;
    logic [DATA_W-1:0]          reg_wdata, reg_rdata, m [6];
    logic                       sample_valid, trigger, qualifying;
    logic signed [SAMPLE_W-1:0] sample;
    logic                       q, hp, pv, ins, et, inr, lng;
    bit                         c;
    int                         cnt, dm, d, i, k, mismatches, checks, cycles;
    int                         seed = 32'h0A9D;
    logic [ADDR_W-1:0]          ofs [6] = '{16'h9C40, 16'h9D08, 16'hA410,
                                            16'hA474, 16'hABE0, 16'h1234};
    logic [DATA_W-1:0]          mode [4] = '{LONG_INNER_MODE,
        SHORT_INNER_MODE, LONG_OUTER_MODE, SHORT_OUTER_MODE};
    wpt_top uut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .sample(sample), .trigger(trigger),
        .qualifying(qualifying));
    wpt_adc_model adc (.clk(clk), .sample_valid(sample_valid),
        .sample(sample));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [DATA_W-1:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask
    function automatic int idx(input logic [ADDR_W-1:0] a);
        for (int j = 0; j < 5; j++)
            if (ofs[j] === a) return j;
        return 5;
    endfunction
    function automatic logic signed [SAMPLE_W-1:0] pick(input bit in_c);
        int r;
        r = $unsigned($random(seed)) % 4;
        if (in_c) return r == 0 ? 12'sh064 : r == 1 ? 12'shF9C : 12'(r * 9);
        return r == 0 ? 12'sh065 : r == 1 ? 12'shF9B : r == 2 ? 12'sh7FF :
               12'sh800;
    endfunction
    task automatic bus(input bit w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] dt);
        @(negedge clk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= dt;
        @(negedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Reference model of what the last clock edge should have produced.
    always @(negedge clk) begin
        et = 1'b0;
        if (!rst_b) begin
            m  = '{GLOBAL_SOURCE_RST, CONDITION_RST, UPPER_LEVEL_RST,
                   LOWER_LEVEL_RST, DURATION_RST, 32'h00000000};
            q  = 1'b0;
            hp = 1'b0;
        end else begin
            if (reg_rd) check(reg_rdata, m[idx(reg_addr)]);
            if (reg_wr && idx(reg_addr) < 5) begin
                m[idx(reg_addr)] = reg_wdata;
                q  = 1'b0;
                hp = 1'b0;
            end else if (sample_valid && m[0] == CHANNEL_TRIGGER_SELECT &&
                         m[1] inside {mode}) begin
                inr = m[1] == mode[0] || m[1] == mode[1];
                lng = m[1] == mode[0] || m[1] == mode[2];
                dm  = m[4][7:0] < 8'h02 ? 2 : int'(m[4][7:0]);
                ins = sample >= $signed(m[3][11:0]) &&
                      sample <= $signed(m[2][11:0]);
                if (hp && q && ins != inr) begin
                    et = !lng;
                    q  = 1'b0;
                end else if (hp && q) begin
                    cnt++;
                    if (cnt >= dm) begin
                        et = lng;
                        q  = 1'b0;
                    end
                end
                if (hp && pv != inr && ins == inr) begin
                    q   = 1'b1;
                    cnt = 1;
                end
                pv = ins;
                hp = 1'b1;
            end
        end
        check(trigger, et);
        check(qualifying, q);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        rst_b     = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        repeat (6) @(negedge clk);
        rst_b <= 1'b1;
        for (k = 0; k < 6; k++) bus(0, ofs[k], 0);
        for (k = 0; k < 8; k++) adc.send(pick(k[0]), 0);
        adc.stop();
        for (i = 0; i < 4; i++) begin
            d = i == 3 ? 255 : i + 2;
            bus(1, ofs[0], CHANNEL_TRIGGER_SELECT);
            bus(1, ofs[1], mode[i]);
            bus(1, ofs[2], 32'h00000064);
            bus(1, ofs[3], 32'hFFFFFF9C);
            bus(1, ofs[4], 32'(d));
            bus(1, ofs[5], 32'hFFFFFFFF);
            for (k = 0; k < 6; k++) bus(0, ofs[k], 0);
            for (k = 0; k < 40; k++) begin
                c = 1'($random(seed));
                repeat (1 + $unsigned($random(seed)) % (d + 1))
                    adc.send(pick(c), $unsigned($random(seed)) % 3);
            end
            $display("mode test %0d done", i);
            if (i == 3) rst_b <= 1'b0;
            adc.stop();
        end
        rst_b <= 1'b1;
        bus(0, ofs[1], 0);
        @(negedge clk);
        $display("reset test done");
        end_sim();
    end
endmodule
